// [hdl/rtc_pkg.sv]
package rtc_pkg;
  // Register word indices on the Avalon-MM address
  localparam int             ADR_W       = 6;
  localparam logic [ADR_W-1:0] ADR_TIME    = 6'h00;
  localparam logic [ADR_W-1:0] ADR_DATE    = 6'h01;
  localparam logic [ADR_W-1:0] ADR_CTRL    = 6'h02;
  localparam logic [ADR_W-1:0] ADR_SUBSEC  = 6'h03;
  localparam logic [ADR_W-1:0] ADR_SHIFT   = 6'h04;
  localparam logic [ADR_W-1:0] ADR_CALIB   = 6'h05;
  localparam logic [ADR_W-1:0] ADR_WKP     = 6'h06;
  localparam logic [ADR_W-1:0] ADR_ALRM_A  = 6'h07;
  localparam logic [ADR_W-1:0] ADR_ALRM_B  = 6'h08;
  localparam logic [ADR_W-1:0] ADR_TAMP    = 6'h09;
  localparam logic [ADR_W-1:0] ADR_TS_TIME = 6'h0a;
  localparam logic [ADR_W-1:0] ADR_TS_DATE = 6'h0b;
  localparam logic [ADR_W-1:0] ADR_STATUS  = 6'h0c;
  localparam logic [ADR_W-1:0] ADR_MASK    = 6'h0d;
  localparam int             ADR_BKP_BIT = 5;      // Upper half holds backup words
  localparam int             BKP_N       = 32;
  localparam int             ST_W        = 7;      // Status/mask width
  localparam int             N_TAMP      = 3;
  // Timing counts in source edges, reference edges and timekeeping pulses
  localparam logic [4:0]     HSC_DIV_LAST = 5'h1f; // High-speed source divided by 32
  localparam logic [5:0]     REF50_LAST   = 6'h31; // 50 reference edges per second
  localparam logic [5:0]     REF60_LAST   = 6'h3b; // 60 reference edges per second
  localparam logic [10:0]    CAL_SLOT     = 11'h000;

  typedef enum logic [1:0] {SRC_LSC = 2'h0, SRC_LSR = 2'h1, SRC_HSC = 2'h2} rtc_src_t;

  // Register layouts, low bits first at the right
  typedef struct packed {logic pm; logic [5:0] hour; logic [6:0] min; logic [6:0] sec;} rtc_time_t;
  typedef struct packed {logic [7:0] year; logic [4:0] month; logic [2:0] wday;
                         logic [5:0] date;} rtc_date_t;
  typedef struct packed {rtc_date_t d; rtc_time_t t;} rtc_cal_t;
  typedef struct packed {logic en; logic [5:0] date; rtc_time_t t;} rtc_alarm_t;
  typedef struct packed {logic [2:0] wkp_sel; logic wkp_en; logic ref60; logic ref_en;
                         logic fmt12; rtc_src_t src;} rtc_ctrl_t;
  typedef struct packed {logic plus; logic [8:0] minus;} rtc_calib_t;
  typedef struct packed {logic [N_TAMP-1:0] en; logic [3:0] filt;} rtc_tamp_t;
  typedef struct packed {logic shut; logic bat; logic [N_TAMP-1:0] tamp; logic ts;
                         logic refc; logic hsc; logic lsr; logic lsc;} rtc_pins_t;

  // Reset values
  localparam rtc_cal_t   CAL_RST   = '{d: '{year: 8'h00, month: 5'h01, wday: 3'h1,
                                           date: 6'h01}, t: '0};
  localparam rtc_ctrl_t  CTRL_RST  = '0;
  localparam logic [16:0] WKP_RST  = 17'h1ffff;
endpackage

// [hdl/rtc_top.sv]
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - Calendar of seconds to year in BCD, binary subseconds, 12 or 24 hour display.
// - Date rolls over by month length, 28/29 leap, 30 and 31.
// - Shift correction delays the time base by 1 to 32767 pulses.
// - With reference enabled, 50 or 60 Hz edges define the second.
// - Calibration adds or drops pulses per 2^20 window, 0.95 ppm step.
// - Three tamper inputs, each through a programmable filter.
// - Timestamp captures calendar on stamp pin, tamper, or battery switch.
// - 17-bit auto-reload wakeup timer, resolution and period programmable.
// - 32 backup words of 32 bits, 128 bytes total.
// - Backup words are not cleared by any reset.
// - Time base from crystal, RC, or high-speed crystal divided by 32.
// - Crystal-clocked, the block runs in battery and all low-power modes.
// - RC-clocked, the block stops in battery mode and shutdown.
// - Alarms, wakeup, timestamp and tamper raise interrupt and wake.
module rtc_top import rtc_pkg::*; (
  // Clock, reset, enable
  input  wire logic              I_CLK_SYS,
  input  wire logic              I_NRST,
  input  wire logic              I_CE,
  // Avalon-MM slave
  input  wire logic [ADR_W-1:0]  I_AVS_ADDRESS,
  input  wire logic              I_AVS_READ,
  input  wire logic              I_AVS_WRITE,
  input  wire logic [31:0]       I_AVS_WRITEDATA,
  output logic      [31:0]       O_AVS_READDATA,
  output logic                   O_AVS_WAITREQUEST,
  // Clock sources and pins
  input  wire logic              I_LOW_SPEED_CRYSTAL_CLOCK,
  input  wire logic              I_LOW_SPEED_RC_CLOCK,
  input  wire logic              I_HIGH_SPEED_CRYSTAL_CLOCK,
  input  wire logic              I_REF_CLOCK,
  input  wire logic              I_TIMESTAMP,
  input  wire logic [N_TAMP-1:0] I_TAMPER,
  input  wire logic              I_BATTERY_MODE,
  input  wire logic              I_SHUTDOWN_MODE,
  // Events
  output logic                   O_IRQ,
  output logic                   O_WAKEUP
);
  rtc_pins_t s1_q, s2_q, s3_q, rise;
  rtc_cal_t cal_q, cal_nx, ts_q;
  rtc_ctrl_t ctrl_q;
  rtc_calib_t calib_q;
  rtc_tamp_t tamp_q;
  rtc_alarm_t alrm_q [2];
  logic [31:0] bkp_q [BKP_N];
  logic [31:0] rd_mux;
  logic [ST_W-1:0] sts_q, mask_q, ev;
  logic [16:0] wkp_q, wkp_rl_q;
  logic [14:0] pre_q, shift_q;
  logic [19:0] win_q;
  logic [15:0] pre_sum;
  logic [5:0] ref_cnt_q;
  logic [4:0] hdiv_q;
  logic [3:0] wdiv_q, wmask;
  logic [3:0] tcnt_q [N_TAMP];
  logic [N_TAMP-1:0] tfired_q, tamp_ev;
  logic [1:0] step, al_hit;
  logic run, src_edge, tk, cal_slot, drop, ins, ref_sec, sec_tick, tick_d_q;
  logic wtick, wkp_ev, ts_trig, new_day, acc, wr, rd;

  // BCD increment of one packed byte
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v == 8'h99) return 8'h00;                          // Year 99 wraps to 00, not a0
    return (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
  endfunction

  // Last date of the month, leap when the BCD year is a multiple of four
  function automatic logic [5:0] last_date(input logic [4:0] m, input logic [7:0] y);
    logic leap;
    leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
    case (m)
      5'h02: return leap ? 6'h29 : 6'h28;
      5'h04, 5'h06, 5'h09, 5'h11: return 6'h30;
      default: return 6'h31;
    endcase
  endfunction

  // Two-stage synchroniser on every pin; third stage only for edge detection
  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else if (I_CE) begin
      s1_q <= {I_SHUTDOWN_MODE, I_BATTERY_MODE, I_TAMPER, I_TIMESTAMP, I_REF_CLOCK,
               I_HIGH_SPEED_CRYSTAL_CLOCK, I_LOW_SPEED_RC_CLOCK, I_LOW_SPEED_CRYSTAL_CLOCK};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  assign rise = rtc_pins_t'(s2_q & ~s3_q);

  // High-speed source divider
  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) hdiv_q <= '0;
    else if (I_CE && rise.hsc) hdiv_q <= hdiv_q + 5'h01;
  end

  // Source select and power-mode gating of the time base
  always_comb begin
    case (ctrl_q.src)
      SRC_LSC: begin
        run = 1'b1;
        src_edge = rise.lsc;
      end
      SRC_LSR: begin
        run = !s2_q.bat && !s2_q.shut;
        src_edge = rise.lsr;
      end
      SRC_HSC: begin
        run = !s2_q.bat && !s2_q.shut;
        src_edge = rise.hsc && hdiv_q == HSC_DIV_LAST;
      end
      default: begin
        run = 1'b0;
        src_edge = 1'b0;
      end
    endcase
  end
  assign tk = run && src_edge;

  // Pending shift drops every pulse; calibration spreads drops over the window
  assign cal_slot = tk && win_q[10:0] == CAL_SLOT;
  assign drop = tk && (shift_q != '0 || (cal_slot && win_q[19:11] < calib_q.minus));
  assign ins = cal_slot && calib_q.plus;
  assign step = 2'(tk) + 2'(ins) - 2'(drop);
  assign pre_sum = {1'b0, pre_q} + 16'(step);
  assign ref_sec = ctrl_q.ref_en && rise.refc
                   && ref_cnt_q == (ctrl_q.ref60 ? REF60_LAST : REF50_LAST);
  assign sec_tick = ctrl_q.ref_en ? ref_sec : pre_sum[15];

  // Prescaler, calibration window and reference counter
  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      pre_q <= '0;
      win_q <= '0;
      ref_cnt_q <= '0;
    end else if (I_CE) begin
      if (tk) win_q <= win_q + 20'h00001;
      // Reference second also realigns the subsecond count
      pre_q <= ref_sec ? 15'h0000 : pre_sum[14:0];
      if (!ctrl_q.ref_en || ref_sec) ref_cnt_q <= '0;
      else if (rise.refc) ref_cnt_q <= ref_cnt_q + 6'h01;
    end
  end

  // Next calendar value one second on
  always_comb begin
    cal_nx = cal_q;
    new_day = 1'b0;
    cal_nx.t.sec = (cal_q.t.sec == 7'h59) ? 7'h00 : 7'(bcd_inc({1'b0, cal_q.t.sec}));
    if (cal_q.t.sec == 7'h59) begin
      cal_nx.t.min = (cal_q.t.min == 7'h59) ? 7'h00 : 7'(bcd_inc({1'b0, cal_q.t.min}));
      if (cal_q.t.min == 7'h59) begin
        if (!ctrl_q.fmt12) begin
          new_day = cal_q.t.hour == 6'h23;
          cal_nx.t.hour = new_day ? 6'h00 : 6'(bcd_inc({2'b0, cal_q.t.hour}));
        end else begin
          new_day = cal_q.t.hour == 6'h11 && cal_q.t.pm;
          if (cal_q.t.hour == 6'h11) cal_nx.t.pm = ~cal_q.t.pm;
          cal_nx.t.hour = (cal_q.t.hour == 6'h12) ? 6'h01 : 6'(bcd_inc({2'b0, cal_q.t.hour}));
        end
      end
    end
    if (new_day) begin
      cal_nx.d.wday = (cal_q.d.wday == 3'h7) ? 3'h1 : cal_q.d.wday + 3'h1;
      if (cal_q.d.date == last_date(cal_q.d.month, cal_q.d.year)) begin
        cal_nx.d.date = 6'h01;
        cal_nx.d.month = (cal_q.d.month == 5'h12) ? 5'h01 : 5'(bcd_inc({3'b0, cal_q.d.month}));
        if (cal_q.d.month == 5'h12) cal_nx.d.year = bcd_inc(cal_q.d.year);
      end else begin
        cal_nx.d.date = 6'(bcd_inc({2'b0, cal_q.d.date}));
      end
    end
  end

  // Calendar register; a software write wins over the tick
  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      cal_q <= CAL_RST;
      tick_d_q <= 1'b0;
    end else if (I_CE) begin
      tick_d_q <= sec_tick;
      if (wr && I_AVS_ADDRESS == ADR_TIME) cal_q.t <= rtc_time_t'(I_AVS_WRITEDATA[20:0]);
      else if (wr && I_AVS_ADDRESS == ADR_DATE) cal_q.d <= rtc_date_t'(I_AVS_WRITEDATA[21:0]);
      else if (sec_tick) cal_q <= cal_nx;
    end
  end

  // Alarms compare one cycle after the calendar has moved
  for (genvar i = 0; i < 2; i++) begin : g_alarm
    assign al_hit[i] = tick_d_q && alrm_q[i].en && cal_q.t == alrm_q[i].t
                       && cal_q.d.date == alrm_q[i].date;
  end

  // Wakeup timer resolution: pulses divided by 16, 8, 4, 2, or seconds
  assign wmask = 4'hf >> ctrl_q.wkp_sel[1:0];
  assign wtick = ctrl_q.wkp_sel[2] ? sec_tick : tk && (wdiv_q & wmask) == wmask;
  assign wkp_ev = ctrl_q.wkp_en && wtick && wkp_q == '0;
  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      wdiv_q <= '0;
      wkp_q <= WKP_RST;
    end else if (I_CE) begin
      if (tk) wdiv_q <= wdiv_q + 4'h1;
      if (!ctrl_q.wkp_en) wkp_q <= wkp_rl_q;
      else if (wkp_ev) wkp_q <= wkp_rl_q;
      else if (wtick) wkp_q <= wkp_q - 17'h00001;
    end
  end

  // Tamper filters: level must hold for the set number of time-base pulses
  for (genvar j = 0; j < N_TAMP; j++) begin : g_tamp
    assign tamp_ev[j] = tk && tamp_q.en[j] && s2_q.tamp[j] && !tfired_q[j]
                        && tcnt_q[j] >= tamp_q.filt;
    always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
      if (!I_NRST) begin
        tcnt_q[j] <= '0;
        tfired_q[j] <= 1'b0;
      end else if (I_CE) begin
        if (!s2_q.tamp[j]) begin
          tcnt_q[j] <= '0;
          tfired_q[j] <= 1'b0;
        end else if (tk) begin
          if (tcnt_q[j] != 4'hf) tcnt_q[j] <= tcnt_q[j] + 4'h1;
          if (tamp_ev[j]) tfired_q[j] <= 1'b1;             // One event per active period
        end
      end
    end
  end

  // Timestamp capture
  assign ts_trig = rise.ts || |tamp_ev || rise.bat;
  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) ts_q <= '0;
    else if (I_CE && ts_trig) ts_q <= cal_q;
  end

  // Backup words carry no reset so they survive every reset
  for (genvar k = 0; k < BKP_N; k++) begin : g_bkp
    always_ff @(posedge I_CLK_SYS) begin
      if (I_CE && wr && I_AVS_ADDRESS[ADR_BKP_BIT] && I_AVS_ADDRESS[4:0] == 5'(k))
        bkp_q[k] <= I_AVS_WRITEDATA;
    end
  end

  // Sticky status: clears only bits that the read returned, so a new event wins
  assign ev = {tamp_ev, ts_trig, wkp_ev, al_hit};
  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      sts_q <= '0;
      O_IRQ <= 1'b0;
      O_WAKEUP <= 1'b0;
    end else if (I_CE) begin
      sts_q <= (sts_q & ~((rd && I_AVS_ADDRESS == ADR_STATUS)
                          ? O_AVS_READDATA[ST_W-1:0] : '0)) | ev;
      O_IRQ <= |(sts_q & mask_q);
      O_WAKEUP <= |ev;
    end
  end

  // Bus slave: one wait cycle, then the request is taken at waitrequest low
  assign acc = (I_AVS_READ || I_AVS_WRITE) && !O_AVS_WAITREQUEST;
  assign wr = acc && I_AVS_WRITE;
  assign rd = acc && I_AVS_READ;
  always_comb begin
    rd_mux = '0;
    if (I_AVS_ADDRESS[ADR_BKP_BIT]) rd_mux = bkp_q[I_AVS_ADDRESS[4:0]];
    else begin
      case (I_AVS_ADDRESS)
        ADR_TIME:    rd_mux = 32'(cal_q.t);
        ADR_DATE:    rd_mux = 32'(cal_q.d);
        ADR_CTRL:    rd_mux = 32'(ctrl_q);
        ADR_SUBSEC:  rd_mux = 32'(pre_q);
        ADR_SHIFT:   rd_mux = 32'(shift_q);
        ADR_CALIB:   rd_mux = 32'(calib_q);
        ADR_WKP:     rd_mux = 32'(wkp_rl_q);
        ADR_ALRM_A:  rd_mux = 32'(alrm_q[0]);
        ADR_ALRM_B:  rd_mux = 32'(alrm_q[1]);
        ADR_TAMP:    rd_mux = 32'(tamp_q);
        ADR_TS_TIME: rd_mux = 32'(ts_q.t);
        ADR_TS_DATE: rd_mux = 32'(ts_q.d);
        ADR_STATUS:  rd_mux = 32'(sts_q);
        ADR_MASK:    rd_mux = 32'(mask_q);
        default:     rd_mux = '0;
      endcase
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      O_AVS_WAITREQUEST <= 1'b1;
      O_AVS_READDATA <= '0;
    end else if (I_CE) begin
      if ((I_AVS_READ || I_AVS_WRITE) && O_AVS_WAITREQUEST) begin
        O_AVS_WAITREQUEST <= 1'b0;
        O_AVS_READDATA <= rd_mux;
      end else begin
        O_AVS_WAITREQUEST <= 1'b1;
      end
    end
  end

  // Control registers written by software
  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      ctrl_q <= CTRL_RST;
      calib_q <= '0;
      wkp_rl_q <= WKP_RST;
      alrm_q[0] <= '0;
      alrm_q[1] <= '0;
      tamp_q <= '0;
      mask_q <= '0;
      shift_q <= '0;
    end else if (I_CE) begin
      if (wr && I_AVS_ADDRESS == ADR_CTRL) ctrl_q <= rtc_ctrl_t'(I_AVS_WRITEDATA[8:0]);
      if (wr && I_AVS_ADDRESS == ADR_CALIB) calib_q <= rtc_calib_t'(I_AVS_WRITEDATA[9:0]);
      if (wr && I_AVS_ADDRESS == ADR_WKP) wkp_rl_q <= I_AVS_WRITEDATA[16:0];
      if (wr && I_AVS_ADDRESS == ADR_ALRM_A) alrm_q[0] <= rtc_alarm_t'(I_AVS_WRITEDATA[27:0]);
      if (wr && I_AVS_ADDRESS == ADR_ALRM_B) alrm_q[1] <= rtc_alarm_t'(I_AVS_WRITEDATA[27:0]);
      if (wr && I_AVS_ADDRESS == ADR_TAMP) tamp_q <= rtc_tamp_t'(I_AVS_WRITEDATA[6:0]);
      if (wr && I_AVS_ADDRESS == ADR_MASK) mask_q <= I_AVS_WRITEDATA[ST_W-1:0];
      if (wr && I_AVS_ADDRESS == ADR_SHIFT) shift_q <= I_AVS_WRITEDATA[14:0];
      else if (tk && shift_q != '0) shift_q <= shift_q - 15'h0001;
    end
  end

  // Checks; frozen cycles are excluded since nothing advances then
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_NRST || !I_CE);

  property p_hour_wrap;
    sec_tick && !wr && !ctrl_q.fmt12 && cal_q.t.hour == 6'h23 && cal_q.t.min == 7'h59
      && cal_q.t.sec == 7'h59 |=> cal_q.t.hour == 6'h00;
  endproperty
  a_hour_wrap: assert property (p_hour_wrap) else $error("24h hour did not wrap");
  property p_month_end;
    sec_tick && !wr && new_day && cal_q.d.date == last_date(cal_q.d.month, cal_q.d.year)
      |=> cal_q.d.date == 6'h01;
  endproperty
  a_month_end: assert property (p_month_end) else $error("date not reset at month end");
  property p_shift_hold;
    shift_q != '0 && tk && !ins && !ref_sec |=> $stable(pre_q);
  endproperty
  a_shift_hold: assert property (p_shift_hold) else $error("shift did not drop pulse");
  property p_ref_second;
    ctrl_q.ref_en && sec_tick |=> pre_q == 15'h0000;
  endproperty
  a_ref_second: assert property (p_ref_second) else $error("reference second not aligned");
  property p_tamp_flag;
    tamp_ev[0] |=> sts_q[4];
  endproperty
  a_tamp_flag: assert property (p_tamp_flag) else $error("tamper flag missing");
  property p_ts_cap;
    ts_trig |=> ts_q == $past(cal_q);
  endproperty
  a_ts_cap: assert property (p_ts_cap) else $error("timestamp not captured");
  property p_wkp_reload;
    wkp_ev && !wr |=> wkp_q == $past(wkp_rl_q) && sts_q[2];
  endproperty
  a_wkp_reload: assert property (p_wkp_reload) else $error("wakeup reload wrong");
  property p_bkp_keep;
    !(wr && I_AVS_ADDRESS == 6'h20) |=> $stable(bkp_q[0]);
  endproperty
  a_bkp_keep: assert property (p_bkp_keep) else $error("backup word changed");
  property p_rc_stop;
    ctrl_q.src == SRC_LSR && s2_q.bat |-> !tk;
  endproperty
  a_rc_stop: assert property (p_rc_stop) else $error("RC source ran in battery mode");
  property p_irq;
    |(sts_q & mask_q) |=> O_IRQ ##1 O_IRQ || !$past(|(sts_q & mask_q));
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");
  property p_alarm;
    al_hit[0] |=> sts_q[0];
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm flag missing");

  c_alarm: cover property (al_hit[0] ##[1:5] O_IRQ);
  c_wkp: cover property (wkp_ev);
  c_tamp: cover property (tamp_ev[2]);
  c_sts_read: cover property (rd && I_AVS_ADDRESS == ADR_STATUS && O_AVS_READDATA != '0);
endmodule
`default_nettype wire

// [verification/rtc_top_test.sv]
`timescale 1ns/100ps
`default_nettype none
module rtc_top_test import rtc_pkg::*; ;
  typedef struct packed {logic [31:0] val; logic [31:0] msk;} rtc_exp_t;

  logic             clk = 1'b0;
  logic             nrst;
  logic [ADR_W-1:0] adr;
  logic             avs_read;
  logic             avs_write;
  logic [31:0]      wdat;
  logic [31:0]      rdat;
  logic             wait_req;
  logic [3:0]       pins;
  logic             ts_pin;
  logic             bat;
  logic             shut;
  logic [2:0]       tamp;
  logic             irq;
  logic             wkup;
  rtc_exp_t         exp_q[$];
  logic [31:0]      bkp[4];
  logic [31:0]      d_pre[5];
  logic [31:0]      d_post[5];
  int               num_errors = 0;
  int               total_checks = 0;
  int               wk_cnt = 0;
  int               k;
  int               n;
  integer           seed = 32'h68e3f18d;

  // 50 MHz system clock
  always #10 clk = ~clk;

  // Pin vector order: crystal, RC, high-speed, reference
  rtc_top rtc_top_inst (
    .I_CLK_SYS(clk), .I_NRST(nrst), .I_CE(1'b1),
    .I_AVS_ADDRESS(adr), .I_AVS_READ(avs_read), .I_AVS_WRITE(avs_write),
    .I_AVS_WRITEDATA(wdat), .O_AVS_READDATA(rdat), .O_AVS_WAITREQUEST(wait_req),
    .I_LOW_SPEED_CRYSTAL_CLOCK(pins[0]), .I_LOW_SPEED_RC_CLOCK(pins[1]),
    .I_HIGH_SPEED_CRYSTAL_CLOCK(pins[2]), .I_REF_CLOCK(pins[3]),
    .I_TIMESTAMP(ts_pin), .I_TAMPER(tamp), .I_BATTERY_MODE(bat),
    .I_SHUTDOWN_MODE(shut), .O_IRQ(irq), .O_WAKEUP(wkup));

  task automatic fail(input string m);
    num_errors++;
    $display("ERROR %0t %s", $time, m);
  endtask

  task automatic cmp_rd(input rtc_exp_t e, input logic [31:0] got);
    total_checks++;
    if ((got & e.msk) !== (e.val & e.msk)) fail($sformatf("read %h expected %h", got, e.val));
  endtask

  task automatic cmp_bit(input logic got, input logic e);
    total_checks++;
    if (got !== e) fail("flag mismatch");
  endtask

  // Request held until waitrequest is sampled low, then released for one edge
  task automatic bus(input logic w, input logic [ADR_W-1:0] a, input logic [31:0] d);
    int c;
    c = 0;
    adr <= a;
    avs_write <= w;
    avs_read <= ~w;
    wdat <= d;
    @(posedge clk);
    while (wait_req !== 1'b0 && c < 100) begin
      @(posedge clk);
      c++;
    end
    if (c >= 100) fail("bus hang");
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [ADR_W-1:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  // The expectation is queued before the request goes out
  task automatic rd(input logic [ADR_W-1:0] a, input logic [31:0] v, input logic [31:0] m);
    exp_q.push_back('{v, m});
    bus(1'b0, a, 32'h0);
  endtask

  // Pins are slow against the system clock: four cycles per level
  task automatic pulses(input int idx, input int cnt);
    repeat (cnt) begin
      pins[idx] <= 1'b1;
      repeat (4) @(posedge clk);
      pins[idx] <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask

  function automatic logic [31:0] tw(input logic pm, input logic [7:0] h, m, s);
    return {11'h000, pm, h[5:0], m[6:0], s[6:0]};
  endfunction

  function automatic logic [31:0] dw(input logic [7:0] y, mo, wd, d);
    return {10'h000, y, mo[4:0], wd[2:0], d[5:0]};
  endfunction

  task automatic do_reset;
    nrst <= 1'b0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
  endtask

  task automatic final_report;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Watcher: takes the oldest note at the edge where read data are taken
  always @(posedge clk) begin
    if (wkup === 1'b1) wk_cnt++;
    if (avs_read === 1'b1 && wait_req === 1'b0) begin
      if (exp_q.size() == 0) fail("read without expectation");
      else cmp_rd(exp_q.pop_front(), rdat);
    end
  end

  // Watchdog well beyond the few thousand cycles the sequence needs
  initial begin
    #(20 * 40000);
    fail("timeout");
    final_report();
  end

  // Main sequence
  initial begin
    nrst = 1'b0; adr = '0; avs_read = 1'b0; avs_write = 1'b0; wdat = '0;
    pins = '0; ts_pin = 1'b0; bat = 1'b0; shut = 1'b0; tamp = '0;
    d_pre = '{dw(8'h01, 8'h02, 8'h1, 8'h28), dw(8'h04, 8'h02, 8'h3, 8'h28),
              dw(8'h04, 8'h02, 8'h5, 8'h29), dw(8'h01, 8'h04, 8'h2, 8'h30),
              dw(8'h99, 8'h12, 8'h7, 8'h31)};
    d_post = '{dw(8'h01, 8'h03, 8'h2, 8'h01), dw(8'h04, 8'h02, 8'h4, 8'h29),
               dw(8'h04, 8'h03, 8'h6, 8'h01), dw(8'h01, 8'h05, 8'h3, 8'h01),
               dw(8'h00, 8'h01, 8'h1, 8'h01)};
    do_reset();
    rd(ADR_TIME, 32'h0, '1);
    rd(ADR_DATE, dw(8'h00, 8'h01, 8'h1, 8'h01), '1);
    rd(ADR_CTRL, 32'h0, '1);
    rd(ADR_WKP, 32'h0001ffff, '1);
    rd(ADR_MASK, 32'h0, '1);
    rd(6'h0e, 32'h0, '1);
    $display("test reset values done");
    // Backup words must survive a reset in mid-run
    for (int i = 0; i < 4; i++) begin
      bkp[i] = $random(seed);
      wr(6'h20 + 6'(i * 9), bkp[i]);
    end
    do_reset();
    for (int i = 0; i < 4; i++) rd(6'h20 + 6'(i * 9), bkp[i], '1);
    $display("test backup done");
    // Day boundary under reference seconds, 50 then 60 edges
    for (int i = 0; i < 5; i++) begin
      n = (i > 2) ? 60 : 50;
      wr(ADR_CTRL, (i > 2) ? 32'h18 : 32'h08);
      wr(ADR_TIME, tw(1'b0, 8'h23, 8'h59, 8'h59));
      wr(ADR_DATE, d_pre[i]);
      pulses(3, n - 1);
      rd(ADR_TIME, tw(1'b0, 8'h23, 8'h59, 8'h59), '1);
      pulses(3, 1);
      rd(ADR_TIME, 32'h0, '1);
      rd(ADR_DATE, d_post[i], '1);
    end
    $display("test rollover done");
    wr(ADR_CTRL, 32'h0c);
    wr(ADR_TIME, tw(1'b0, 8'h11, 8'h59, 8'h59));
    pulses(3, 50);
    rd(ADR_TIME, tw(1'b1, 8'h12, 8'h00, 8'h00), '1);
    $display("test twelve hour done");
    // Two alarms one second apart, both unmasked
    wr(ADR_MASK, 32'h7f);
    wr(ADR_ALRM_A, 32'h08200000 | tw(1'b1, 8'h12, 8'h00, 8'h01));
    wr(ADR_ALRM_B, 32'h08200000 | tw(1'b1, 8'h12, 8'h00, 8'h02));
    k = wk_cnt;
    pulses(3, 50);
    repeat (20) @(posedge clk);
    cmp_bit(irq, 1'b1);
    cmp_bit(logic'(wk_cnt - k == 1), 1'b1);
    rd(ADR_STATUS, 32'h01, 32'h7f);
    repeat (2) @(posedge clk);
    cmp_bit(irq, 1'b0);
    pulses(3, 50);
    rd(ADR_STATUS, 32'h02, 32'h7f);
    $display("test alarms done");
    // Tamper fires on the pulse after three filtered pulses; first pulse is a drop slot
    wr(ADR_MASK, 32'h0);
    wr(ADR_CTRL, 32'h0);
    wr(ADR_CALIB, 32'h00000001);
    wr(ADR_TIME, tw(1'b0, 8'h10, 8'h20, 8'h30));
    wr(ADR_TAMP, 32'h13);
    tamp <= 3'b001;
    pulses(0, 3);
    rd(ADR_STATUS, 32'h0, 32'h7f);
    pulses(0, 1);
    rd(ADR_STATUS, 32'h18, 32'h7f);
    cmp_bit(irq, 1'b0);
    rd(ADR_TS_TIME, tw(1'b0, 8'h10, 8'h20, 8'h30), '1);
    tamp <= 3'b000;
    ts_pin <= 1'b1;
    repeat (6) @(posedge clk);
    ts_pin <= 1'b0;
    repeat (6) @(posedge clk);
    rd(ADR_STATUS, 32'h08, 32'h7f);
    bat <= 1'b1;
    repeat (6) @(posedge clk);
    rd(ADR_STATUS, 32'h08, 32'h7f);
    $display("test tamper and stamp done");
    // Wakeup at pulses/2, reload 2: three ticks, six pulses per event
    wr(ADR_WKP, 32'h2);
    wr(ADR_CTRL, 32'he0);
    pulses(0, 4);
    rd(ADR_STATUS, 32'h0, 32'h7f);
    pulses(0, 4);
    rd(ADR_STATUS, 32'h04, 32'h7f);
    $display("test wakeup done");
    // Shift drains one count per time-base pulse; source choice seen through it
    wr(ADR_CTRL, 32'h0);
    wr(ADR_SHIFT, 32'h5);
    rd(ADR_SHIFT, 32'h5, '1);
    pulses(0, 4);
    rd(ADR_SHIFT, 32'h1, '1);
    pulses(0, 1);
    rd(ADR_SHIFT, 32'h0, '1);
    wr(ADR_CTRL, 32'h1);
    wr(ADR_SHIFT, 32'h2);
    pulses(1, 2);
    rd(ADR_SHIFT, 32'h2, '1);
    bat <= 1'b0;
    shut <= 1'b1;
    pulses(1, 2);
    rd(ADR_SHIFT, 32'h2, '1);
    shut <= 1'b0;
    pulses(1, 2);
    rd(ADR_SHIFT, 32'h0, '1);
    wr(ADR_CTRL, 32'h2);
    wr(ADR_SHIFT, 32'h2);
    pulses(2, 32);
    rd(ADR_SHIFT, 32'h1, '1);
    // Twelve counted pulses since reset, one lost to the calibration slot
    rd(ADR_SUBSEC, 32'h0000000b, '1);
    $display("test shift and sources done");
    final_report();
  end
endmodule
`default_nettype wire
